//--- rtl/coproc_xfer_pkg.sv
package coproc_xfer_pkg;
  localparam int WORD_W = 32;
  localparam int RNUM_W = 4;
  localparam int COND_HI = 31;
  localparam int COND_LO = 28;
  localparam int CLASS_HI = 27;
  localparam int CLASS_LO = 24;
  localparam int OPC_HI = 23;
  localparam int OPC_LO = 21;
  localparam int DIR_BIT = 20;
  localparam int XREG_HI = 19;
  localparam int XREG_LO = 16;
  localparam int CORE_REG_HI = 15;
  localparam int CORE_REG_LO = 12;
  localparam int NUM_HI = 11;
  localparam int NUM_LO = 8;
  localparam int INFO_HI = 7;
  localparam int INFO_LO = 5;
  localparam int XFER_BIT = 4;
  localparam int OPND_HI = 3;
  localparam int OPND_LO = 0;
  localparam logic [3:0] CLASS_CDP_RT = 4'he;
  // Undefined class: bits 27:25 = 3'b011 with bit 4 set
  localparam logic [2:0] UNDEF_CLASS = 3'h3;
  localparam logic [3:0] PC_REG = 4'hf;
  localparam logic [WORD_W-1:0] PC_XFER_OFFSET = 32'h0000000c;
  // Flag positions inside the flag nibble: N Z C V
  localparam int FLAG_N = 3;
  localparam int FLAG_Z = 2;
  localparam int FLAG_C = 1;
  localparam int FLAG_V = 0;
  localparam int COND_AL = 14;
  localparam int COND_NV = 15;
  // Phase codes presented on the handshake, for cycle accounting
  typedef enum logic [1:0] {
    PH_S = 2'h0,
    PH_N = 2'h1,
    PH_I = 2'h2,
    PH_C = 2'h3
  } cycle_kind_t;
endpackage

//--- rtl/coproc_link_if.sv
`timescale 1ns/100ps
`default_nettype none
interface coproc_link_if;
  import coproc_xfer_pkg::*;
  logic offer;
  logic [WORD_W-1:0] instr;
  cycle_kind_t phase;
  logic coproc_absent_line;
  logic coproc_busy_line;
  logic [WORD_W-1:0] core_data;
  logic [WORD_W-1:0] coproc_data;
  modport core (
    output offer,
    output instr,
    output phase,
    output core_data,
    input coproc_absent_line,
    input coproc_busy_line,
    input coproc_data
  );
  modport coproc (
    input offer,
    input instr,
    input phase,
    input core_data,
    output coproc_absent_line,
    output coproc_busy_line,
    output coproc_data
  );
endinterface
`default_nettype wire

//--- rtl/coproc_core_end.sv
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RL1 - Execute only when condition passes flags
// RL2 - Number field picks the addressed coprocessor
// RL3 - Bit 20 picks transfer direction
// RL4 - Bits 15:12 name the core register
// RL5 - Coprocessor register from bits 19:16
// RL6 - Second coprocessor operand from bits 3:0
// RL7 - Opcode and info fields belong to coprocessor
// RL8 - PC destination copies word bits into flags
// RL9 - PC destination changes nothing else
// RL10 - PC source supplies instruction address plus 12
// RL11 - Coproc-to-core: 1S, (b+1)I, 1C
// RL12 - Core-to-coproc: 1S, bI, 1C
// RL13 - True undefined instruction takes the trap
// RL14 - Undefined instruction offered to coprocessors first
// RL15 - Coprocessors refuse with absent and busy high
// RL16 - Undefined handling: 2S, 1I, 1N
// RL17 - Busy inserts internal waits before transfer
// RL18 - Sender drives word during C cycle
module coproc_core_end
  import coproc_xfer_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic START_I,
  input wire logic [coproc_xfer_pkg::WORD_W-1:0] INSTR_I,
  input wire logic [coproc_xfer_pkg::WORD_W-1:0] INSTR_ADDR_I,
  input wire logic [3:0] FLAGS_I,
  input wire logic [coproc_xfer_pkg::WORD_W-1:0] REG_RDATA_I,
  output logic [3:0] REG_RADDR_O,
  output logic DONE_O,
  output logic REG_WE_O,
  output logic [3:0] REG_WADDR_O,
  output logic [coproc_xfer_pkg::WORD_W-1:0] REG_WDATA_O,
  output logic FLAGS_WE_O,
  output logic [3:0] FLAGS_O,
  output logic UNDEF_TRAP_O,
  output logic ABSENT_TRAP_O,
  output logic [1:0] CYCLE_KIND_O,
  coproc_link_if.core link
);
  import coproc_xfer_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_S = 3'h1,
    ST_WAIT = 3'h3,
    ST_XFER = 3'h2,
    ST_UND_S2 = 3'h6,
    ST_UND_I = 3'h7,
    ST_UND_N = 3'h5
  } state_t;

  function automatic logic cond_pass(input logic [3:0] c, input logic [3:0] f);
    logic n, z, cy, v;
    n = f[FLAG_N];
    z = f[FLAG_Z];
    cy = f[FLAG_C];
    v = f[FLAG_V];
    case (c)
      4'h0: cond_pass = z;
      4'h1: cond_pass = !z;
      4'h2: cond_pass = cy;
      4'h3: cond_pass = !cy;
      4'h4: cond_pass = n;
      4'h5: cond_pass = !n;
      4'h6: cond_pass = v;
      4'h7: cond_pass = !v;
      4'h8: cond_pass = cy && !z;
      4'h9: cond_pass = !cy || z;
      4'ha: cond_pass = n == v;
      4'hb: cond_pass = n != v;
      4'hc: cond_pass = !z && (n == v);
      4'hd: cond_pass = z || (n != v);
      4'he: cond_pass = 1'b1;
      default: cond_pass = 1'b0;
    endcase
  endfunction

  state_t state, next_state;
  logic [WORD_W-1:0] instr, next_instr;
  logic [WORD_W-1:0] addr, next_addr;
  logic offer, next_offer;
  cycle_kind_t phase, next_phase;
  logic [WORD_W-1:0] cdata, next_cdata;
  logic done, next_done;
  logic reg_we, next_reg_we;
  logic [WORD_W-1:0] reg_wdata, next_reg_wdata;
  logic flags_we, next_flags_we;
  logic [3:0] flags_out, next_flags_out;
  logic und_trap, next_und_trap;
  logic abs_trap, next_abs_trap;
  logic is_rt, is_und, to_core;

  assign is_rt = INSTR_I[CLASS_HI:CLASS_LO] == CLASS_CDP_RT && INSTR_I[XFER_BIT];
  assign is_und = INSTR_I[CLASS_HI:CLASS_LO+1] == UNDEF_CLASS && INSTR_I[XFER_BIT];
  assign to_core = instr[DIR_BIT]; // RL3
  // Register read port is combinational; source read happens in the S cycle, or in the last I cycle when busy
  assign REG_RADDR_O = instr[CORE_REG_HI:CORE_REG_LO]; // RL4

  always_comb begin
    next_state = state;
    next_instr = instr;
    next_addr = addr;
    next_offer = offer;
    next_phase = phase;
    next_cdata = cdata;
    next_done = 1'b0;
    next_reg_we = 1'b0;
    next_reg_wdata = reg_wdata;
    next_flags_we = 1'b0;
    next_flags_out = flags_out;
    next_und_trap = 1'b0;
    next_abs_trap = 1'b0;
    case (state)
      ST_IDLE: begin
        if (START_I) begin
          next_instr = INSTR_I;
          next_addr = INSTR_ADDR_I;
          if (!cond_pass(INSTR_I[COND_HI:COND_LO], FLAGS_I) || !(is_rt || is_und)) begin
            next_done = 1'b1; // RL1
          end else begin
            // Instruction goes out with the number field; only the match answers
            next_offer = 1'b1; // RL2 RL14
            next_phase = PH_S;
            next_state = ST_S;
          end
        end
      end
      ST_S: begin
        if (instr[CLASS_HI:CLASS_LO] != CLASS_CDP_RT) begin
          next_phase = PH_S;
          next_state = ST_UND_S2; // RL16
        end else if (link.coproc_absent_line) begin
          next_offer = 1'b0;
          next_abs_trap = 1'b1;
          next_done = 1'b1;
          next_state = ST_IDLE;
        end else if (link.coproc_busy_line || to_core) begin
          next_phase = PH_I; // RL11 RL17
          next_state = ST_WAIT;
        end else begin
          // PC as source reads instruction address plus 12
          next_cdata = (REG_RADDR_O == PC_REG) ? addr + PC_XFER_OFFSET : REG_RDATA_I; // RL10
          next_phase = PH_C; // RL12
          next_state = ST_XFER;
        end
      end
      ST_WAIT: begin
        if (!link.coproc_busy_line) begin // RL17
          if (!to_core) begin
            next_cdata = (REG_RADDR_O == PC_REG) ? addr + PC_XFER_OFFSET : REG_RDATA_I; // RL10
          end
          next_phase = PH_C;
          next_state = ST_XFER;
        end
      end
      ST_XFER: begin
        next_offer = 1'b0;
        next_phase = PH_S;
        next_done = 1'b1;
        next_state = ST_IDLE;
        if (to_core) begin
          if (instr[CORE_REG_HI:CORE_REG_LO] == PC_REG) begin
            // Only the top nibble lands in the flags; PC untouched
            next_flags_we = 1'b1; // RL9
            next_flags_out = link.coproc_data[COND_HI:COND_LO]; // RL8
          end else begin
            next_reg_we = 1'b1; // RL18
            next_reg_wdata = link.coproc_data;
          end
        end
      end
      ST_UND_S2: begin
        next_offer = 1'b0;
        next_phase = PH_I;
        next_state = ST_UND_I;
      end
      ST_UND_I: begin
        next_phase = PH_N;
        next_state = ST_UND_N;
      end
      ST_UND_N: begin
        next_phase = PH_S;
        next_und_trap = 1'b1; // RL13 RL15
        next_done = 1'b1;
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
        next_offer = 1'b0;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      state <= ST_IDLE;
      instr <= '0;
      addr <= '0;
      offer <= 1'b0;
      phase <= PH_S;
      cdata <= '0;
      done <= 1'b0;
      reg_we <= 1'b0;
      reg_wdata <= '0;
      flags_we <= 1'b0;
      flags_out <= '0;
      und_trap <= 1'b0;
      abs_trap <= 1'b0;
    end else begin
      state <= next_state;
      instr <= next_instr;
      addr <= next_addr;
      offer <= next_offer;
      phase <= next_phase;
      cdata <= next_cdata;
      done <= next_done;
      reg_we <= next_reg_we;
      reg_wdata <= next_reg_wdata;
      flags_we <= next_flags_we;
      flags_out <= next_flags_out;
      und_trap <= next_und_trap;
      abs_trap <= next_abs_trap;
    end
  end

  assign link.offer = offer;
  assign link.instr = instr;
  assign link.phase = phase;
  assign link.core_data = cdata; // RL18
  assign DONE_O = done;
  assign REG_WE_O = reg_we;
  assign REG_WADDR_O = instr[CORE_REG_HI:CORE_REG_LO];
  assign REG_WDATA_O = reg_wdata;
  assign FLAGS_WE_O = flags_we;
  assign FLAGS_O = flags_out;
  assign UNDEF_TRAP_O = und_trap;
  assign ABSENT_TRAP_O = abs_trap;
  assign CYCLE_KIND_O = phase;
endmodule // coproc_core_end
`default_nettype wire

//--- rtl/coproc_unit_end.sv
`timescale 1ns/100ps
`default_nettype none
module coproc_unit_end
  import coproc_xfer_pkg::*;
(
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic [3:0] MY_NUMBER_I,
  input wire logic BUSY_REQ_I,
  input wire logic [coproc_xfer_pkg::WORD_W-1:0] REG_RDATA_I,
  output logic [3:0] REG_RADDR_O,
  output logic REG_WE_O,
  output logic [3:0] REG_WADDR_O,
  output logic [coproc_xfer_pkg::WORD_W-1:0] REG_WDATA_O,
  output logic [3:0] OPERAND_REG_O,
  output logic [2:0] OPCODE_O,
  output logic [2:0] INFO_O,
  coproc_link_if.coproc link
);
  import coproc_xfer_pkg::*;

  logic mine, is_rt, granted;
  logic we, next_we;
  logic [WORD_W-1:0] wdata, next_wdata;
  logic [3:0] waddr, next_waddr;
  logic [3:0] opnd, next_opnd;
  logic [2:0] opc, next_opc;
  logic [2:0] info, next_info;
  logic [WORD_W-1:0] rdata, next_rdata;

  assign mine = link.instr[NUM_HI:NUM_LO] == MY_NUMBER_I; // RL2
  assign is_rt = link.instr[CLASS_HI:CLASS_LO] == CLASS_CDP_RT && link.instr[XFER_BIT];
  assign granted = link.offer && is_rt && mine;
  assign REG_RADDR_O = link.instr[XREG_HI:XREG_LO]; // RL5

  always_comb begin
    next_we = 1'b0;
    next_wdata = wdata;
    next_waddr = waddr;
    next_opnd = opnd;
    next_opc = opc;
    next_info = info;
    next_rdata = rdata;
    if (granted) begin
      next_opnd = link.instr[OPND_HI:OPND_LO]; // RL6
      next_opc = link.instr[OPC_HI:OPC_LO]; // RL7
      next_info = link.instr[INFO_HI:INFO_LO];
      next_rdata = REG_RDATA_I;
      if (link.phase == PH_C && !link.instr[DIR_BIT]) begin
        next_we = 1'b1; // RL18
        next_wdata = link.core_data;
        next_waddr = link.instr[XREG_HI:XREG_LO];
      end
    end
    // Anything else, undefined class included, is refused
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      we <= 1'b0;
      wdata <= '0;
      waddr <= '0;
      opnd <= '0;
      opc <= '0;
      info <= '0;
      rdata <= '0;
    end else begin
      we <= next_we;
      wdata <= next_wdata;
      waddr <= next_waddr;
      opnd <= next_opnd;
      opc <= next_opc;
      info <= next_info;
      rdata <= next_rdata;
    end
  end

  // Answer lines are combinational: the core samples them at the end of its S cycle,
  // a registered answer would arrive one cycle late and read as absent
  assign link.coproc_absent_line = !granted; // RL15
  assign link.coproc_busy_line = !granted || BUSY_REQ_I; // RL17
  assign link.coproc_data = rdata;
  assign REG_WE_O = we;
  assign REG_WADDR_O = waddr;
  assign REG_WDATA_O = wdata;
  assign OPERAND_REG_O = opnd;
  assign OPCODE_O = opc;
  assign INFO_O = info;
endmodule // coproc_unit_end
`default_nettype wire

//--- verif/coproc_link_chk.sv
`timescale 1ns/100ps
`default_nettype none
module coproc_link_chk
  import coproc_xfer_pkg::*;
#(
  parameter logic [3:0] CPN = 4'h5
)
(
  input wire logic CLK_I,
  input wire logic SRST_I,
  input wire logic offer,
  input wire logic [coproc_xfer_pkg::WORD_W-1:0] instr,
  input wire coproc_xfer_pkg::cycle_kind_t phase,
  input wire logic coproc_absent_line,
  input wire logic coproc_busy_line,
  input wire logic [coproc_xfer_pkg::WORD_W-1:0] core_data,
  input wire logic [coproc_xfer_pkg::WORD_W-1:0] coproc_data
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  wire logic xfer = instr[27:24] == CLASS_CDP_RT && instr[XFER_BIT];
  wire logic undef = instr[27:25] == UNDEF_CLASS && instr[XFER_BIT];
  sequence s_undef_walk;
    phase == PH_S ##1 phase == PH_S ##1 phase == PH_I ##1 phase == PH_N;
  endsequence
  a_undef_walk: assert property ($rose(offer) && undef |-> s_undef_walk)
    else $error("undefined phase order wrong");
  a_undef_refused: assert property (offer && undef |-> coproc_absent_line && coproc_busy_line)
    else $error("undefined not refused");
  a_other_number: assert property (offer && instr[11:8] != CPN |=> coproc_absent_line)
    else $error("unaddressed unit answered");
  a_starts_seq: assert property ($rose(offer) && xfer |-> phase == PH_S)
    else $error("transfer not opened by S");
  a_single_c: assert property (phase == PH_C |=> phase != PH_C)
    else $error("more than one C cycle");
  a_c_after_ready: assert property (phase == PH_C |-> !$past(coproc_busy_line))
    else $error("C cycle while busy");
  a_fetch_wait: assert property (phase == PH_C && instr[DIR_BIT] |-> $past(phase) == PH_I)
    else $error("no I cycle before C");
  a_instr_held: assert property (offer && $past(offer) |-> $stable(instr))
    else $error("offered word changed");
  a_offer_ends: assert property ($rose(offer) |-> ##[1:60] !offer)
    else $error("offer never ended");
endmodule // coproc_link_chk
`default_nettype wire

//--- verif/coproc_register_transfer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module coproc_register_transfer_tb;
  import coproc_xfer_pkg::*;
  localparam logic [3:0] CPN = 4'h5;
  typedef struct packed {
    logic cwe; logic [3:0] cwa; logic [31:0] cwd; logic fwe; logic [3:0] fl;
    logic utr; logic atr; logic uwe; logic [3:0] uwa; logic [31:0] uwd; logic [9:0] fld;
  } res_t;
  logic CLK_I = 0, SRST_I = 1, start = 0, busy = 0;
  logic [31:0] instr = 0, iaddr = 0, cwd, uwd;
  logic [31:0] crf [16], urf [16];
  logic [3:0] flags = 0, cra, ura, cwa, uwa, fl, opd;
  logic [2:0] opc, inf;
  logic [1:0] kind;
  logic done, cwe, fwe, utr, atr, uwe;
  int seed = 76, error_cnt = 0, n_tests = 0, cyc = 0;
  always #2.5 CLK_I = ~CLK_I;
  coproc_link_if link ();
  coproc_core_end coproc_core_end_inst (.CLK_I(CLK_I), .SRST_I(SRST_I), .START_I(start),
    .INSTR_I(instr), .INSTR_ADDR_I(iaddr), .FLAGS_I(flags), .REG_RDATA_I(crf[cra]),
    .REG_RADDR_O(cra), .DONE_O(done), .REG_WE_O(cwe), .REG_WADDR_O(cwa), .REG_WDATA_O(cwd),
    .FLAGS_WE_O(fwe), .FLAGS_O(fl), .UNDEF_TRAP_O(utr), .ABSENT_TRAP_O(atr),
    .CYCLE_KIND_O(kind), .link(link));
  coproc_unit_end coproc_unit_end_inst (.CLK_I(CLK_I), .SRST_I(SRST_I), .MY_NUMBER_I(CPN),
    .BUSY_REQ_I(busy), .REG_RDATA_I(urf[ura]), .REG_RADDR_O(ura), .REG_WE_O(uwe),
    .REG_WADDR_O(uwa), .REG_WDATA_O(uwd), .OPERAND_REG_O(opd), .OPCODE_O(opc),
    .INFO_O(inf), .link(link));
  coproc_link_chk #(.CPN(CPN)) coproc_link_chk_inst (.CLK_I(CLK_I), .SRST_I(SRST_I),
    .offer(link.offer), .instr(link.instr), .phase(link.phase),
    .coproc_absent_line(link.coproc_absent_line), .coproc_busy_line(link.coproc_busy_line),
    .core_data(link.core_data), .coproc_data(link.coproc_data));
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Ceiling well above the roughly 900 cycles the sequence needs
  always @(posedge CLK_I) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  function automatic logic cond_ok(logic [3:0] c, logic [3:0] f);
    logic r;
    case (c[3:1])
      3'h0: r = f[FLAG_Z];
      3'h1: r = f[FLAG_C];
      3'h2: r = f[FLAG_N];
      3'h3: r = f[FLAG_V];
      3'h4: r = f[FLAG_C] & !f[FLAG_Z];
      3'h5: r = f[FLAG_N] == f[FLAG_V];
      3'h6: r = !f[FLAG_Z] & (f[FLAG_N] == f[FLAG_V]);
      default: r = 1'b1;
    endcase
    return c == 4'hf ? 1'b0 : r ^ c[0];
  endfunction
  function automatic res_t exp_res(logic [31:0] i, logic [3:0] f, logic [31:0] a);
    res_t e;
    logic p;
    e = '0;
    p = cond_ok(i[31:28], f);
    e.utr = p && i[27:25] == UNDEF_CLASS && i[4];
    if (p && i[27:24] == CLASS_CDP_RT && i[4]) begin
      e.atr = i[11:8] != CPN;
      if (!e.atr) begin
        e.fld = {i[3:0], i[23:21], i[7:5]};
        if (!i[DIR_BIT]) begin
          e.uwe = 1'b1;
          e.uwa = i[19:16];
          e.uwd = i[15:12] == PC_REG ? a + PC_XFER_OFFSET : crf[i[15:12]];
        end else if (i[15:12] == PC_REG) begin
          e.fwe = 1'b1;
          e.fl = urf[i[19:16]][31:28];
        end else begin
          e.cwe = 1'b1;
          e.cwa = i[15:12];
          e.cwd = urf[i[19:16]];
        end
      end
    end
    return e;
  endfunction
  function automatic logic [31:0] mk(logic [3:0] c, logic d, logic [3:0] rd, logic [3:0] n);
    logic [31:0] i;
    i = $random(seed);
    i[31:28] = c;
    i[27:24] = CLASS_CDP_RT;
    i[DIR_BIT] = d;
    i[15:12] = rd;
    i[11:8] = n;
    i[4] = 1'b1;
    return i;
  endfunction
  task automatic cmp_res(string nm, res_t e, res_t g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp_kinds(string nm, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  // Busy is held nb cycles; phase counts are exact only when nb is zero
  task automatic run(logic [31:0] i, logic [3:0] f, int nb);
    res_t e, g;
    logic [15:0] k, ke;
    logic dn, ux;
    g = '0;
    k = '0;
    dn = 1'b0;
    @(posedge CLK_I);
    start <= 1'b1;
    instr <= i;
    flags <= f;
    iaddr <= $random(seed);
    busy <= nb > 0;
    @(posedge CLK_I);
    start <= 1'b0;
    e = exp_res(i, f, iaddr);
    for (int t = 0; t < 60 && !dn; t++) begin
      #1;
      if (cwe) {g.cwe, g.cwa, g.cwd} = {1'b1, cwa, cwd};
      if (fwe) {g.fwe, g.fl} = {1'b1, fl};
      if (uwe) {g.uwe, g.uwa, g.uwd} = {1'b1, uwa, uwd};
      g.utr |= utr;
      g.atr |= atr;
      k[15] |= link.offer;
      if (kind == PH_I) k[11:8]++;
      if (kind == PH_C) k[7:4]++;
      if (kind == PH_N) k[3:0]++;
      dn = done;
      @(posedge CLK_I);
      if (t + 1 == nb) busy <= 1'b0;
    end
    if (e.uwe | e.cwe | e.fwe) g.fld = {opd, opc, inf};
    cmp_res("result", e, g);
    ux = i[27:25] == UNDEF_CLASS && i[4];
    ke = '0;
    ke[15] = cond_ok(i[31:28], f) && (ux || (i[27:24] == CLASS_CDP_RT && i[4]));
    if (ke[15]) ke[11:0] = ux ? 12'h101 : {3'h0, i[DIR_BIT], 8'h10};
    if (nb == 0 && !e.atr) cmp_kinds("phases", ke, k);
    if (!dn) cmp_kinds("done", 16'h1, 16'h0);
  endtask
  initial begin
    logic [31:0] i;
    for (int j = 0; j < 16; j++) begin
      crf[j] = $random(seed);
      urf[j] = $random(seed);
    end
    repeat (5) @(posedge CLK_I);
    SRST_I <= 1'b0;
    for (int q = 0; q < 4; q++) run(mk(4'he, q[0], q[1] ? PC_REG : 4'h3, CPN), 4'h0, 0);
    run(mk(4'he, 1'b1, 4'h3, CPN ^ 4'h1), 4'h0, 0);
    for (int c = 0; c < 16; c++) run(mk(4'(c), 1'b1, 4'h2, CPN), 4'($random(seed)), 0);
    for (int j = 0; j < 150; j++) begin
      i = mk(4'($random(seed)), 1'($random(seed)), 4'($random(seed)),
        ($random(seed) & 3) != 0 ? CPN : 4'($random(seed)));
      if (j % 3 == 0) i[27:25] = UNDEF_CLASS;
      run(i, 4'($random(seed)), j % 4);
    end
    close_out();
  end
endmodule // coproc_register_transfer_tb
`default_nettype wire
